// *** switch_global_ctrl_pkg.sv ***
// Constants shared by the global control register bank and its storm meter
package switch_global_ctrl_pkg;

    // ============================================================
    // Register offsets
    localparam logic [7:0] ADDR_MII_PORT_AND_STORM_HIGH = 8'h06;
    localparam logic [7:0] ADDR_STORM_RATE_LOW          = 8'h07;
    localparam logic [7:0] ADDR_FACTORY_TEST_A          = 8'h08;
    localparam logic [7:0] ADDR_FACTORY_TEST_B          = 8'h09;
    localparam logic [7:0] ADDR_FACTORY_TEST_C          = 8'h0a;
    localparam logic [7:0] ADDR_POWER_SAVE_CONTROL      = 8'h0b;

    // ============================================================
    // Field positions
    localparam int BIT_MII_RSVD7      = 7;
    localparam int BIT_MII_HALF_DUP   = 6;
    localparam int BIT_MII_FLOW_CTRL  = 5;
    localparam int BIT_MII_10M        = 4;
    localparam int BIT_NULL_VID_REPL  = 3;
    localparam int STORM_HIGH_MSB     = 2;
    localparam int BIT_PHY_POWER_SAVE = 6;
    localparam int BIT_PS_RSVD5       = 5;

    // ============================================================
    // Widths
    localparam int STORM_W = 11;
    localparam int VID_W   = 12;
    localparam int TIMER_W = 24;

    // ============================================================
    // Reset values
    localparam logic       RST_MII_RSVD7     = 1'h0;
    localparam logic       RST_NULL_VID_REPL = 1'h0;
    localparam logic [2:0] RST_STORM_HIGH    = 3'h0;
    localparam logic [7:0] RST_STORM_LOW     = 8'h63;
    localparam logic [7:0] RST_FACTORY_A     = 8'h4e;
    localparam logic [7:0] RST_FACTORY_B     = 8'h24;
    localparam logic [7:0] RST_FACTORY_C     = 8'h24;
    localparam logic       RST_POWER_SAVE    = 1'h0;
    localparam logic       RST_PS_RSVD5      = 1'h0;

    // ============================================================
    // Timing
    localparam int CLK_HZ           = 25000000;
    localparam int INTERVAL_10_MS   = 500;
    localparam int INTERVAL_100_MS  = 67;
    localparam int INTERVAL_10_CYC  = (CLK_HZ / 1000) * INTERVAL_10_MS;
    localparam int INTERVAL_100_CYC = (CLK_HZ / 1000) * INTERVAL_100_MS;

endpackage : switch_global_ctrl_pkg

// *** storm_if.sv ***
// Link between the register bank and the broadcast storm meter
`timescale 1ns/100ps
interface storm_if #(
    parameter int NUM_PORTS = 3
);
    logic [switch_global_ctrl_pkg::STORM_W-1:0] threshold;
    logic [NUM_PORTS-1:0]                       port_10m;
    logic [NUM_PORTS-1:0]                       bcast_block;
    logic [NUM_PORTS-1:0]                       blocked;

    modport bank (
        output threshold,
        output port_10m,
        output bcast_block,
        input  blocked
    );

    modport meter (
        input  threshold,
        input  port_10m,
        input  bcast_block,
        output blocked
    );
endinterface : storm_if

// *** storm_meter.sv ***
// Per-port broadcast storm meter: interval timers and block counters
`timescale 1ns/100ps
module storm_meter #(
    parameter int NUM_PORTS        = 3,
    parameter int INTERVAL_10_CYC  = switch_global_ctrl_pkg::INTERVAL_10_CYC,
    parameter int INTERVAL_100_CYC = switch_global_ctrl_pkg::INTERVAL_100_CYC
) (
    // Clock, reset and enable
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic ce_i,
    // Bank side
    storm_if.meter    mtr
);
    localparam int TW = switch_global_ctrl_pkg::TIMER_W;
    localparam int SW = switch_global_ctrl_pkg::STORM_W;

    typedef struct packed {
        logic [NUM_PORTS-1:0][TW-1:0] timer;
        logic [NUM_PORTS-1:0][SW-1:0] count;
        logic [NUM_PORTS-1:0]         blocked;
    } meter_t;

    meter_t st_q;
    meter_t st_d;

    // Reload value, one less than the interval length in cycles, for the port's current speed
    function automatic logic [TW-1:0] reload(input logic is_10m);
        reload = is_10m ? TW'(INTERVAL_10_CYC - 1) : TW'(INTERVAL_100_CYC - 1);
    endfunction : reload

    // ============================================================
    // Counting
    always_comb begin
        st_d = st_q;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (st_q.timer[p] == '0) begin
                st_d.timer[p] = reload(mtr.port_10m[p]);
                st_d.count[p] = mtr.bcast_block[p] ? SW'(1) : '0;
            end else begin
                st_d.timer[p] = st_q.timer[p] - TW'(1);
                if (mtr.bcast_block[p] && (st_q.count[p] != '1)) begin
                    st_d.count[p] = st_q.count[p] + SW'(1);
                end
            end
            st_d.blocked[p] = (st_d.count[p] >= mtr.threshold);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    assign mtr.blocked = st_q.blocked;

endmodule : storm_meter

// *** switch_global_control_regs.sv ***
// Global control registers 6 to 11 with MII port, storm and power-save control
//
// Notes on behaviour
// - Register 6 bit 5 enables MII full-duplex flow control and resets to the flow strap.
// - Register 6 bit 4 selects 10 Mbps on the MII port and resets to the speed strap.
// - Register 6 bit 3 replaces a null VLAN ID with the port default ID and resets to 0.
// - The 11-bit storm threshold is register 6 bits 2-0 above register 7.
// - The storm interval is 500 ms at 10 Mbps and 67 ms at 100 Mbps.
// - The storm threshold resets to 0x63 low and 000 high.
// - Register 11 bit 6 enables PHY power save and resets to 0.
// - Register 6 bit 6 selects MII half duplex and resets to the duplex strap.
`timescale 1ns/100ps
module switch_global_control_regs #(
    parameter int NUM_PORTS        = 3,
    parameter int INTERVAL_10_CYC  = switch_global_ctrl_pkg::INTERVAL_10_CYC,
    parameter int INTERVAL_100_CYC = switch_global_ctrl_pkg::INTERVAL_100_CYC
) (
    // Clock, reset, enable
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       ce_i,
    // Strap pins
    input  wire logic                       flow_control_strap_pin_i,
    input  wire logic                       speed_strap_pin_i,
    input  wire logic                       duplex_strap_pin_i,
    // Register access
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       reg_rd_i,
    output logic      [7:0]                 reg_rdata_o,
    output logic                            reg_rvalid_o,
    // MII port, PHY power-save and storm threshold control
    output logic                            mii_half_duplex_o,
    output logic                            mii_flow_ctrl_o,
    output logic                            mii_10m_o,
    output logic                            phy_power_save_o,
    output logic      [10:0]                storm_threshold_o,
    // Broadcast storm metering
    input  wire logic [NUM_PORTS-2:0]       phy_10m_i,
    input  wire logic [NUM_PORTS-1:0]       bcast_block_i,
    output logic      [NUM_PORTS-1:0]       storm_drop_o,
    // VLAN ID path
    input  wire logic [NUM_PORTS-1:0]       tag_valid_i,
    input  wire logic [NUM_PORTS-1:0][11:0] tag_vid_i,
    input  wire logic [NUM_PORTS-1:0][11:0] default_vid_i,
    output logic      [NUM_PORTS-1:0]       tag_valid_o,
    output logic      [NUM_PORTS-1:0][11:0] tag_vid_o
);
    localparam int SW = switch_global_ctrl_pkg::STORM_W;
    localparam int VW = switch_global_ctrl_pkg::VID_W;

    // ============================================================
    // State
    typedef struct packed {
        logic                         strap_pend;
        logic                         mii_rsvd7;
        logic                         half_duplex;
        logic                         flow_ctrl;
        logic                         mii_10m;
        logic                         null_vid_repl;
        logic [2:0]                   storm_high;
        logic [7:0]                   storm_low;
        logic [7:0]                   factory_a;
        logic [7:0]                   factory_b;
        logic [7:0]                   factory_c;
        logic                         power_save;
        logic                         ps_rsvd5;
        logic [7:0]                   rdata;
        logic                         rvalid;
        logic [NUM_PORTS-1:0]         vid_valid;
        logic [NUM_PORTS-1:0][VW-1:0] vid;
    } bank_t;

    localparam bank_t BANK_RST = '{
        strap_pend:    1'h1,
        mii_rsvd7:     switch_global_ctrl_pkg::RST_MII_RSVD7,
        half_duplex:   1'h0,
        flow_ctrl:     1'h0,
        mii_10m:       1'h0,
        null_vid_repl: switch_global_ctrl_pkg::RST_NULL_VID_REPL,
        storm_high:    switch_global_ctrl_pkg::RST_STORM_HIGH,
        storm_low:     switch_global_ctrl_pkg::RST_STORM_LOW,
        factory_a:     switch_global_ctrl_pkg::RST_FACTORY_A,
        factory_b:     switch_global_ctrl_pkg::RST_FACTORY_B,
        factory_c:     switch_global_ctrl_pkg::RST_FACTORY_C,
        power_save:    switch_global_ctrl_pkg::RST_POWER_SAVE,
        ps_rsvd5:      switch_global_ctrl_pkg::RST_PS_RSVD5,
        rdata:         8'h00,
        rvalid:        1'h0,
        vid_valid:     '0,
        vid:           '0
    };

    bank_t st_q;
    bank_t st_d;

    // Register 6 as seen by software
    function automatic logic [7:0] mii_reg(input bank_t s);
        mii_reg = '0;
        mii_reg[switch_global_ctrl_pkg::BIT_MII_RSVD7]     = s.mii_rsvd7;
        mii_reg[switch_global_ctrl_pkg::BIT_MII_HALF_DUP]  = s.half_duplex;
        mii_reg[switch_global_ctrl_pkg::BIT_MII_FLOW_CTRL] = s.flow_ctrl;
        mii_reg[switch_global_ctrl_pkg::BIT_MII_10M]       = s.mii_10m;
        mii_reg[switch_global_ctrl_pkg::BIT_NULL_VID_REPL] = s.null_vid_repl;
        mii_reg[switch_global_ctrl_pkg::STORM_HIGH_MSB:0]  = s.storm_high;
    endfunction : mii_reg

    // Register 11 as seen by software; unimplemented bits read zero
    function automatic logic [7:0] ps_reg(input bank_t s);
        ps_reg = '0;
        ps_reg[switch_global_ctrl_pkg::BIT_PHY_POWER_SAVE] = s.power_save;
        ps_reg[switch_global_ctrl_pkg::BIT_PS_RSVD5]       = s.ps_rsvd5;
    endfunction : ps_reg

    // ============================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                switch_global_ctrl_pkg::ADDR_MII_PORT_AND_STORM_HIGH: begin
                    st_d.mii_rsvd7     = reg_wdata_i[switch_global_ctrl_pkg::BIT_MII_RSVD7];
                    st_d.half_duplex   = reg_wdata_i[switch_global_ctrl_pkg::BIT_MII_HALF_DUP];
                    st_d.flow_ctrl     = reg_wdata_i[switch_global_ctrl_pkg::BIT_MII_FLOW_CTRL];
                    st_d.mii_10m       = reg_wdata_i[switch_global_ctrl_pkg::BIT_MII_10M];
                    st_d.null_vid_repl = reg_wdata_i[switch_global_ctrl_pkg::BIT_NULL_VID_REPL];
                    st_d.storm_high    = reg_wdata_i[switch_global_ctrl_pkg::STORM_HIGH_MSB:0];
                end
                switch_global_ctrl_pkg::ADDR_STORM_RATE_LOW: begin
                    st_d.storm_low = reg_wdata_i;
                end
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_A: begin
                    st_d.factory_a = reg_wdata_i;
                end
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_B: begin
                    st_d.factory_b = reg_wdata_i;
                end
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_C: begin
                    st_d.factory_c = reg_wdata_i;
                end
                switch_global_ctrl_pkg::ADDR_POWER_SAVE_CONTROL: begin
                    st_d.power_save = reg_wdata_i[switch_global_ctrl_pkg::BIT_PHY_POWER_SAVE];
                    st_d.ps_rsvd5   = reg_wdata_i[switch_global_ctrl_pkg::BIT_PS_RSVD5];
                end
                default: begin
                end
            endcase
        end

        // Strap load on the first enabled edge after reset
        if (st_q.strap_pend) begin
            st_d.strap_pend  = 1'b0;
            st_d.flow_ctrl   = flow_control_strap_pin_i;
            st_d.mii_10m     = speed_strap_pin_i;
            st_d.half_duplex = duplex_strap_pin_i;
        end

        // Reads return the value before any same-cycle write
        st_d.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                switch_global_ctrl_pkg::ADDR_MII_PORT_AND_STORM_HIGH: st_d.rdata = mii_reg(st_q);
                switch_global_ctrl_pkg::ADDR_STORM_RATE_LOW:          st_d.rdata = st_q.storm_low;
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_A:          st_d.rdata = st_q.factory_a;
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_B:          st_d.rdata = st_q.factory_b;
                switch_global_ctrl_pkg::ADDR_FACTORY_TEST_C:          st_d.rdata = st_q.factory_c;
                switch_global_ctrl_pkg::ADDR_POWER_SAVE_CONTROL:      st_d.rdata = ps_reg(st_q);
                default:                                              st_d.rdata = 8'h00;
            endcase
        end

        // Null VLAN ID replacement
        st_d.vid_valid = tag_valid_i;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (tag_valid_i[p]) begin
                if (st_q.null_vid_repl && (tag_vid_i[p] == '0)) begin
                    st_d.vid[p] = default_vid_i[p];
                end else begin
                    st_d.vid[p] = tag_vid_i[p];
                end
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= BANK_RST;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ============================================================
    // Storm meter
    storm_if #(
        .NUM_PORTS (NUM_PORTS)
    ) storm_link ();

    assign storm_link.threshold   = {st_q.storm_high, st_q.storm_low};
    assign storm_link.port_10m    = {st_q.mii_10m, phy_10m_i};
    assign storm_link.bcast_block = bcast_block_i;

    storm_meter #(
        .NUM_PORTS        (NUM_PORTS),
        .INTERVAL_10_CYC  (INTERVAL_10_CYC),
        .INTERVAL_100_CYC (INTERVAL_100_CYC)
    ) storm_meter_i (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .mtr       (storm_link)
    );

    // ============================================================
    // Outputs
    assign reg_rdata_o       = st_q.rdata;
    assign reg_rvalid_o      = st_q.rvalid;
    assign mii_half_duplex_o = st_q.half_duplex;
    assign mii_flow_ctrl_o   = st_q.flow_ctrl;
    assign mii_10m_o         = st_q.mii_10m;
    assign phy_power_save_o  = st_q.power_save;
    assign storm_threshold_o = SW'({st_q.storm_high, st_q.storm_low});
    assign storm_drop_o      = storm_link.blocked;
    assign tag_valid_o       = st_q.vid_valid;
    assign tag_vid_o         = st_q.vid;

endmodule : switch_global_control_regs

// *** switch_global_control_regs_asserts.sv ***
// Port assertions for the global control register bank
`timescale 1ns/100ps
module switch_global_control_regs_asserts #(
    parameter int NUM_PORTS = 3
) (
    // Clock, reset, enable
    input wire logic                       ref_clk_i,
    input wire logic                       sys_rst_i,
    input wire logic                       ce_i,
    // Straps and register access
    input wire logic                       flow_control_strap_pin_i,
    input wire logic                       speed_strap_pin_i,
    input wire logic                       duplex_strap_pin_i,
    input wire logic [7:0]                 reg_addr_i,
    input wire logic                       reg_wr_i,
    input wire logic [7:0]                 reg_wdata_i,
    input wire logic                       reg_rd_i,
    input wire logic                       reg_rvalid_o,
    // Control outputs
    input wire logic                       mii_half_duplex_o,
    input wire logic                       mii_flow_ctrl_o,
    input wire logic                       mii_10m_o,
    input wire logic                       phy_power_save_o,
    input wire logic [10:0]                storm_threshold_o,
    // Storm and VLAN ID paths
    input wire logic [NUM_PORTS-1:0]       bcast_block_i,
    input wire logic [NUM_PORTS-1:0]       storm_drop_o,
    input wire logic [NUM_PORTS-1:0]       tag_valid_i,
    input wire logic [NUM_PORTS-1:0][11:0] tag_vid_i,
    input wire logic [NUM_PORTS-1:0][11:0] tag_vid_o
);
    // ============================================================
    // Helper state
    logic armed_q;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed_q <= 1'b0;
        end else if (ce_i) begin
            armed_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_rd;
        ce_i && reg_rd_i;
    endsequence
    sequence s_wr(a);
        ce_i && reg_wr_i && reg_addr_i == a;
    endsequence

    // ============================================================
    // Assertions
    AST_RD_ANSWER: assert property (s_rd |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    AST_RD_PULSE: assert property (ce_i && !reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without read");
    AST_STRAP_LOAD: assert property (!armed_q && ce_i |=>
        {mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o} ==
        $past({duplex_strap_pin_i, flow_control_strap_pin_i, speed_strap_pin_i}))
        else $error("strap levels not loaded");
    AST_MII_WRITE: assert property (armed_q ##0 s_wr(8'h06) |=>
        {mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o} == $past(reg_wdata_i[6:4]))
        else $error("port mode write lost");
    AST_THR_HIGH: assert property (s_wr(8'h06) |=>
        storm_threshold_o[10:8] == $past(reg_wdata_i[2:0]))
        else $error("threshold high write lost");
    AST_THR_LOW: assert property (s_wr(8'h07) |=>
        storm_threshold_o[7:0] == $past(reg_wdata_i))
        else $error("threshold low write lost");
    AST_PS_WRITE: assert property (s_wr(8'h0b) |=>
        phy_power_save_o == $past(reg_wdata_i[6]))
        else $error("power save write lost");
    AST_RST_VALUE: assert property ($fell(sys_rst_i) |->
        storm_threshold_o == 11'h063 && !phy_power_save_o)
        else $error("wrong reset value");
    AST_DROP_CAUSE: assert property ($rose(storm_drop_o[0]) &&
        $past(storm_threshold_o) != 11'h000 &&
        $past(storm_threshold_o) == $past(storm_threshold_o, 2) |-> $past(bcast_block_i[0]))
        else $error("drop without counted block");
    AST_VID_PASS: assert property (ce_i && tag_valid_i[1] &&
        tag_vid_i[1] != 12'h000 |=> tag_vid_o[1] == $past(tag_vid_i[1]))
        else $error("non-null id altered");
endmodule : switch_global_control_regs_asserts

bind switch_global_control_regs switch_global_control_regs_asserts #(
    .NUM_PORTS(NUM_PORTS)
) switch_global_control_regs_asserts_i (.*);

// *** host_model.sv ***
// Host model issuing register writes and reads
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Register access
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // ============================================================
    // Bus cycles
    // Factory test registers are never written; reserved bits are only ever written as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        v = reg_rvalid_i;
        d = reg_rdata_i;
    endtask : rd
endmodule : host_model

// *** switch_global_control_regs_bench.sv ***
// Self-checking bench for the global control register bank
`timescale 1ns/100ps
module switch_global_control_regs_bench;
    localparam int NP = 3;
    localparam int I10 = 40;
    localparam int I100 = 20;
    logic                 ref_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    logic                 ce_i = 1'b1;
    logic                 flow_control_strap_pin_i = 1'b1;
    logic                 speed_strap_pin_i = 1'b0;
    logic                 duplex_strap_pin_i = 1'b1;
    logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic                 reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic                 mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o, phy_power_save_o;
    logic [10:0]          storm_threshold_o;
    logic [NP-2:0]        phy_10m_i = 2'h1;
    logic [NP-1:0]        bcast_block_i = 3'h0, tag_valid_i = 3'h0, storm_drop_o, tag_valid_o;
    logic [NP-1:0][11:0]  tag_vid_i = '0, default_vid_i = {3{12'h5a5}}, tag_vid_o;
    int                   errors = 0;
    int                   checks_done = 0;

    switch_global_control_regs #(.NUM_PORTS(NP), .INTERVAL_10_CYC(I10),
        .INTERVAL_100_CYC(I100)) switch_global_control_regs_i (.*);
    host_model host_model_i (
        .ref_clk_i    (ref_clk_i),
        .reg_addr_o   (reg_addr_i),
        .reg_wr_o     (reg_wr_i),
        .reg_wdata_o  (reg_wdata_i),
        .reg_rd_o     (reg_rd_i),
        .reg_rdata_i  (reg_rdata_o),
        .reg_rvalid_i (reg_rvalid_o)
    );

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // ============================================================
    // Helpers
    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask : step

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host_model_i.rd(a, d, v);
        check(v, 1'h1);
        check(d, exp);
    endtask : rdc

    task automatic report_and_stop;
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // ============================================================
    // Scenarios
    task automatic t_defaults;
        check({mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o}, 3'h6);
        check(storm_threshold_o, 11'h063);
        check(phy_power_save_o, 1'h0);
        rdc(8'h06, 8'h60);
        rdc(8'h07, 8'h63);
        rdc(8'h08, 8'h4e);
        rdc(8'h09, 8'h24);
        rdc(8'h0a, 8'h24);
        rdc(8'h0b, 8'h00);
        host_model_i.wr(8'h0c, 8'h5a);
        rdc(8'h0c, 8'h00);
    endtask : t_defaults

    task automatic t_writes;
        host_model_i.wr(8'h06, 8'h1d);
        host_model_i.wr(8'h07, 8'h10);
        check({mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o}, 3'h1);
        check(storm_threshold_o, 11'h510);
        rdc(8'h06, 8'h1d);
        host_model_i.wr(8'h0b, 8'h40);
        check(phy_power_save_o, 1'h1);
        rdc(8'h0b, 8'h40);
        host_model_i.wr(8'h0b, 8'h00);
        check(phy_power_save_o, 1'h0);
    endtask : t_writes

    // Write with the enable low must not land
    task automatic t_freeze;
        ce_i = 1'b0;
        host_model_i.wr(8'h07, 8'h55);
        check(storm_threshold_o, 11'h510);
        ce_i = 1'b1;
    endtask : t_freeze

    task automatic vid(input logic [11:0] v, input logic [11:0] exp);
        tag_vid_i[1] = v;
        tag_valid_i[1] = 1'b1;
        step();
        tag_valid_i[1] = 1'b0;
        check(tag_valid_o[1], 1'h1);
        check(tag_vid_o[1], exp);
        step();
    endtask : vid

    task automatic t_vid;
        vid(12'h000, 12'h5a5);
        vid(12'h123, 12'h123);
        host_model_i.wr(8'h06, 8'h15);
        vid(12'h000, 12'h000);
    endtask : t_vid

    // Blocks every cycle: low run is threshold less one, period is the interval
    task automatic measure(input int p, input int lo_exp, input int per_exp);
        int n;
        int lo;
        int per;
        n = 0;
        lo = 0;
        per = 0;
        bcast_block_i[p] = 1'b1;
        while (storm_drop_o[p] !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        while (storm_drop_o[p] !== 1'b0 && n < 400) begin
            step();
            n++;
        end
        while (storm_drop_o[p] !== 1'b1 && n < 600) begin
            step();
            lo++;
            n++;
        end
        per = lo;
        while (storm_drop_o[p] !== 1'b0 && n < 800) begin
            step();
            per++;
            n++;
        end
        bcast_block_i[p] = 1'b0;
        check(16'(lo), 16'(lo_exp));
        check(16'(per), 16'(per_exp));
    endtask : measure

    task automatic t_storm;
        host_model_i.wr(8'h06, 8'h10);
        host_model_i.wr(8'h07, 8'h03);
        measure(0, 2, I10);
        measure(1, 2, I100);
        measure(2, 2, I10);
        host_model_i.wr(8'h06, 8'h00);
        measure(2, 2, I100);
    endtask : t_storm

    // Mid-run reset with other strap levels
    task automatic t_reset;
        flow_control_strap_pin_i = 1'b0;
        speed_strap_pin_i = 1'b1;
        duplex_strap_pin_i = 1'b0;
        sys_rst_i = 1'b1;
        repeat (2) step();
        check(storm_threshold_o, 11'h063);
        sys_rst_i = 1'b0;
        step();
        check({mii_half_duplex_o, mii_flow_ctrl_o, mii_10m_o}, 3'h1);
        check(phy_power_save_o, 1'h0);
        rdc(8'h06, 8'h10);
    endtask : t_reset

    // ============================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (3) step();
        t_defaults();
        t_writes();
        t_freeze();
        t_vid();
        t_storm();
        t_reset();
        report_and_stop();
    end

    initial begin
        #200000;
        errors++;
        report_and_stop();
    end
endmodule : switch_global_control_regs_bench
